// ===== hw/fkt_keepalive_tx.sv
`timescale 1ns/100ps
module fkt_keepalive_tx #(
  parameter int unsigned CHIP_CYCLES = fkt_pkg::CHIP_CYCLES,
  parameter int unsigned CNT_W = 20,
  parameter int unsigned PWM_W = 6
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic txEnable,
  input wire logic txBitValue,
  input wire logic txModeDac,
  output logic toneActive,
  output logic chipMark,
  output logic cycleStart,
  output logic pwmOut,
  output logic [7:0] dacSample
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (CHIP_CYCLES < 2 || CHIP_CYCLES > (2 ** CNT_W)) begin : g_chk_chip
    $error("chip count does not fit the chip timer");
  end
  if (PWM_W < 2 || PWM_W > 8) begin : g_chk_pwm
    $error("pwm carrier width must be 2 to 8 bits");
  end

  localparam logic [CNT_W-1:0] CHIP_LAST = CNT_W'(CHIP_CYCLES - 1);
  localparam logic [3:0] CHIP_IDX_LAST = 4'(fkt_pkg::WORD_CHIPS - 1);
  localparam logic [4:0] ACT_WORD_LAST = 5'(fkt_pkg::ACTIVE_WORDS - 1);
  localparam logic [4:0] QUIET_WORD_LAST = 5'(fkt_pkg::QUIET_WORDS - 1);

  // quarter-wave sine, half-sample offset so the mirror needs no extra entry
  function automatic logic [6:0] fkt_quarter(input logic [2:0] idx);
    logic [6:0] val;
    val = 7'h00;
    unique case (idx)
      3'h0: val = 7'h0C;
      3'h1: val = 7'h25;
      3'h2: val = 7'h3C;
      3'h3: val = 7'h51;
      3'h4: val = 7'h62;
      3'h5: val = 7'h70;
      3'h6: val = 7'h7A;
      3'h7: val = 7'h7E;
    endcase
    return val;
  endfunction : fkt_quarter

  // offset-binary sine from the top five phase bits
  function automatic logic [7:0] fkt_sine(input logic [4:0] ph);
    logic [6:0] mag;
    mag = fkt_quarter(ph[3] ? ~ph[2:0] : ph[2:0]);
    return ph[4] ? (fkt_pkg::DAC_MID - {1'b0, mag}) : (fkt_pkg::DAC_MID + {1'b0, mag});
  endfunction : fkt_sine

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] syncA_q;
  logic [2:0] syncB_q;

  // pins arrive from outside the clock domain; stage A feeds stage B only
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      syncA_q <= 3'h0;
      syncB_q <= 3'h0;
    end else begin
      syncA_q <= {txModeDac, txBitValue, txEnable};
      syncB_q <= syncA_q;
    end
  end

  logic enSync;
  logic bitSync;
  logic modeSync;
  assign enSync = syncB_q[0];
  assign bitSync = syncB_q[1];
  assign modeSync = syncB_q[2];

  // ----------------------------------------------------------------
  // packet sequencer
  // ----------------------------------------------------------------
  fkt_pkg::fkt_state_type state_q;
  fkt_pkg::fkt_state_type state_d;
  logic [CNT_W-1:0] chipTimer_q;
  logic [3:0] chipIdx_q;
  logic [4:0] wordIdx_q;
  logic bitLatch_q;
  logic modeLatch_q;
  logic chipEnd;
  logic wordEnd;
  logic startCycle;

  assign chipEnd = (chipTimer_q == CHIP_LAST);
  assign wordEnd = chipEnd && (chipIdx_q == CHIP_IDX_LAST);

  // next state; the quiet gap flows straight into the next packet while enable is held, else back to idle
  always_comb begin
    state_d = state_q;
    startCycle = 1'b0;
    unique case (state_q)
      fkt_pkg::ST_IDLE: begin
        if (enSync) begin
          state_d = fkt_pkg::ST_ACTIVE;
          startCycle = 1'b1;
        end
      end
      fkt_pkg::ST_ACTIVE: begin
        if (wordEnd && wordIdx_q == ACT_WORD_LAST) begin
          state_d = fkt_pkg::ST_QUIET;
        end
      end
      fkt_pkg::ST_QUIET: begin
        if (wordEnd && wordIdx_q == QUIET_WORD_LAST) begin
          startCycle = enSync;
          state_d = enSync ? fkt_pkg::ST_ACTIVE : fkt_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = fkt_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= fkt_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // chip timer and chip index run through active and quiet alike
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      chipTimer_q <= '0;
      chipIdx_q <= 4'h0;
    end else if (state_q == fkt_pkg::ST_IDLE || startCycle) begin
      chipTimer_q <= '0;
      chipIdx_q <= 4'h0;
    end else if (chipEnd) begin
      chipTimer_q <= '0;
      chipIdx_q <= (chipIdx_q == CHIP_IDX_LAST) ? 4'h0 : chipIdx_q + 4'h1;
    end else begin
      chipTimer_q <= chipTimer_q + CNT_W'(1);
    end
  end

  // word index restarts at each phase change so quiet counts from zero
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wordIdx_q <= 5'h00;
    end else if (state_q == fkt_pkg::ST_IDLE || state_d != state_q) begin
      wordIdx_q <= 5'h00;
    end else if (wordEnd) begin
      wordIdx_q <= wordIdx_q + 5'h01;
    end
  end

  // value and mode held for a whole cycle so a packet never changes midway
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bitLatch_q <= 1'b0;
      modeLatch_q <= 1'b0;
    end else if (startCycle) begin
      bitLatch_q <= bitSync;
      modeLatch_q <= modeSync;
    end
  end

  // ----------------------------------------------------------------
  // chip selection
  // ----------------------------------------------------------------
  logic [10:0] codeWord;
  logic chipNow;
  logic sending;

  assign codeWord = bitLatch_q ? fkt_pkg::ONE_CODE_WORD : fkt_pkg::ZERO_CODE_WORD;
  assign chipNow = codeWord[4'd10 - chipIdx_q];
  assign sending = (state_q == fkt_pkg::ST_ACTIVE);

  // ----------------------------------------------------------------
  // shared phase accumulator
  // ----------------------------------------------------------------
  logic [31:0] phase_q;

  // one accumulator for both tones: switching only changes the step,
  // so the waveform stays continuous across a chip boundary
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= fkt_pkg::PHASE_RST;
    end else begin
      phase_q <= phase_q + (chipNow ? fkt_pkg::MARK_FTW : fkt_pkg::SPACE_FTW);
    end
  end

  // ----------------------------------------------------------------
  // output drive
  // ----------------------------------------------------------------
  logic [PWM_W-1:0] pwmCnt_q;
  logic [7:0] sineNow;

  assign sineNow = fkt_sine(phase_q[31:27]);

  // free-running pwm carrier, ~2 MHz at the default width; coarse on purpose,
  // the front-end filter removes the carrier
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pwmCnt_q <= '0;
    end else begin
      pwmCnt_q <= pwmCnt_q + PWM_W'(1);
    end
  end

  // both drives parked when idle: pwm low, dac at midscale
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pwmOut <= 1'b0;
      dacSample <= fkt_pkg::DAC_MID;
    end else begin
      pwmOut <= sending && !modeLatch_q && (sineNow[7 -: PWM_W] > pwmCnt_q);
      dacSample <= (sending && modeLatch_q) ? sineNow : fkt_pkg::DAC_MID;
    end
  end

  // status outputs
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      toneActive <= 1'b0;
      chipMark <= 1'b0;
      cycleStart <= 1'b0;
    end else begin
      toneActive <= sending;
      chipMark <= sending && chipNow;
      cycleStart <= startCycle;
    end
  end

endmodule : fkt_keepalive_tx

// ===== hw/fkt_pkg.sv
package fkt_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_FREQ_HZ = 125000000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  // chip period 5.12 ms, kept in ns so the figure stays exact
  localparam int unsigned CHIP_PERIOD_NS = 5120000;
  localparam int unsigned CHIP_CYCLES = CHIP_PERIOD_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // packet framing
  // ----------------------------------------------------------------
  localparam int unsigned WORD_CHIPS = 11;
  localparam int unsigned ACTIVE_WORDS = 3;
  localparam int unsigned QUIET_WORDS = 16;
  localparam int unsigned CYCLE_WORDS = ACTIVE_WORDS + QUIET_WORDS;
  // first chip sent is bit 10; 1 = mark, 0 = space
  localparam logic [10:0] ONE_CODE_WORD = 11'h0ED;
  localparam logic [10:0] ZERO_CODE_WORD = ~ONE_CODE_WORD;

  // ----------------------------------------------------------------
  // tones: 32-bit phase increments rounded to nearest
  // ----------------------------------------------------------------
  localparam longint unsigned MARK_TONE_FREQ_HZ = 131250;
  localparam longint unsigned SPACE_TONE_FREQ_HZ = 143750;
  localparam logic [31:0] MARK_FTW = 32'(((MARK_TONE_FREQ_HZ << 32) + CLK_FREQ_HZ / 2) / CLK_FREQ_HZ);
  localparam logic [31:0] SPACE_FTW = 32'(((SPACE_TONE_FREQ_HZ << 32) + CLK_FREQ_HZ / 2) / CLK_FREQ_HZ);

  // ----------------------------------------------------------------
  // output coding and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] DAC_MID = 8'h80;
  localparam logic [31:0] PHASE_RST = 32'h00000000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_QUIET = 3'b100
  } fkt_state_type;

endpackage : fkt_pkg

// ===== test/fkt_front_end_model.sv
`timescale 1ns/100ps
module fkt_front_end_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic startIn,
  input wire logic pwmIn,
  input wire logic [7:0] dacIn,
  output logic pwmSeen_q,
  output logic dacSeen_q
);
  // ----------------
  // line activity
  // ----------------
  // flags drop at each start so every packet is judged on its own drive
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pwmSeen_q <= 1'h0;
      dacSeen_q <= 1'h0;
    end else begin
      pwmSeen_q <= !startIn && (pwmSeen_q || pwmIn);
      dacSeen_q <= !startIn && (dacSeen_q || dacIn != 8'h80);
    end
  end
endmodule : fkt_front_end_model

// ===== test/fkt_keepalive_tx_sva.sv
`timescale 1ns/100ps
module fkt_keepalive_tx_sva #(
  parameter int unsigned CHIP_CYCLES = 8
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic txEnable,
  input wire logic txBitValue,
  input wire logic txModeDac,
  input wire logic toneActive,
  input wire logic chipMark,
  input wire logic cycleStart,
  input wire logic pwmOut,
  input wire logic [7:0] dacSample
);
  logic [31:0] actCnt_q;
  logic [31:0] perCnt_q;
  // ----------------
  // helper counters
  // ----------------
  // active run length; cycles since last start, 0 until the first one
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      actCnt_q <= 32'h0;
      perCnt_q <= 32'h0;
    end else begin
      actCnt_q <= toneActive ? actCnt_q + 32'h1 : 32'h0;
      perCnt_q <= cycleStart ? 32'h1 : perCnt_q + {31'h0, |perCnt_q};
    end
  end
  // ----------------
  // properties
  // ----------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  property p_len; $fell(toneActive) |-> actCnt_q == 33 * CHIP_CYCLES; endproperty
  a_len: assert property (p_len) else $error("active length wrong");
  property p_per; cycleStart |-> perCnt_q == 0 || perCnt_q >= 19 * 11 * CHIP_CYCLES; endproperty
  a_per: assert property (p_per) else $error("cycle start too early");
  property p_start; cycleStart |=> !cycleStart && $rose(toneActive); endproperty
  a_start: assert property (p_start) else $error("packet did not follow start");
  property p_chip; toneActive && $past(toneActive) && $changed(chipMark) |-> actCnt_q % CHIP_CYCLES == 0; endproperty
  a_chip: assert property (p_chip) else $error("chip edge off boundary");
  property p_word; toneActive && actCnt_q >= 11 * CHIP_CYCLES |-> chipMark == $past(chipMark, 11 * CHIP_CYCLES);
  endproperty
  a_word: assert property (p_word) else $error("words differ");
  property p_mark; chipMark |-> toneActive; endproperty
  a_mark: assert property (p_mark) else $error("mark outside packet");
  property p_quiet; !toneActive |-> !pwmOut && dacSample == 8'h80; endproperty
  a_quiet: assert property (p_quiet) else $error("tone while quiet");
  property p_drive; pwmOut |-> dacSample == 8'h80; endproperty
  a_drive: assert property (p_drive) else $error("both drives active");
  // one shared phase base moves at most one table step per clock, so a restart at a chip edge shows as a jump
  property p_smooth; toneActive && $past(toneActive) |->
    (dacSample >= $past(dacSample) ? dacSample - $past(dacSample) : $past(dacSample) - dacSample) <= 8'h19;
  endproperty
  a_smooth: assert property (p_smooth) else $error("phase jump in tone");
endmodule : fkt_keepalive_tx_sva

bind fkt_keepalive_tx fkt_keepalive_tx_sva #(.CHIP_CYCLES(CHIP_CYCLES)) i_fkt_keepalive_tx_sva (
  .clk_sys(clk_sys), .rst_b(rst_b), .txEnable(txEnable), .txBitValue(txBitValue), .txModeDac(txModeDac),
  .toneActive(toneActive), .chipMark(chipMark), .cycleStart(cycleStart), .pwmOut(pwmOut), .dacSample(dacSample));

// ===== test/fkt_keepalive_tx_test.sv
`timescale 1ns/100ps
module fkt_keepalive_tx_test;
  // short chips keep the run small; the period and chip checks below scale with it, the wait bounds do not
  localparam int unsigned CHIP = 8;
  logic clk_sys = 1'h0;
  logic rst_b = 1'h0;
  logic txEnable = 1'h0;
  logic txBitValue = 1'h0;
  logic txModeDac = 1'h0;
  logic toneActive, chipMark, cycleStart, pwmOut, pwmSeen_q, dacSeen_q;
  logic [7:0] dacSample;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  int prevStart = 0;
  // ----------------
  // block and line model
  // ----------------
  fkt_keepalive_tx #(.CHIP_CYCLES(CHIP)) i_fkt_keepalive_tx (.clk_sys(clk_sys), .rst_b(rst_b),
    .txEnable(txEnable), .txBitValue(txBitValue), .txModeDac(txModeDac), .toneActive(toneActive),
    .chipMark(chipMark), .cycleStart(cycleStart), .pwmOut(pwmOut), .dacSample(dacSample));
  fkt_front_end_model i_fkt_front_end_model (.clk_sys(clk_sys), .rst_b(rst_b), .startIn(cycleStart),
    .pwmIn(pwmOut), .dacIn(dacSample), .pwmSeen_q(pwmSeen_q), .dacSeen_q(dacSeen_q));
  // clock and a cycle count for period checks
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;
  // ----------------
  // shared tasks
  // ----------------
  task automatic give_verdict();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  // bounded wait; a missing start ends the run
  task automatic wait_start(input int bound);
    for (int i = 0; i < bound && cycleStart !== 1'h1; i++) begin
      @(negedge clk_sys);
    end
    if (cycleStart !== 1'h1) begin
      n_mismatch++;
      $display("mismatch at %0t: no cycle start", $time);
      give_verdict();
    end
  endtask : wait_start
  // ----------------
  // scenarios
  // ----------------
  // inputs flip right after the start to prove they are latched
  task automatic sc_packet(input logic val, input logic dac);
    logic [10:0] word;
    word = val ? 11'h0ED : ~11'h0ED;
    txBitValue = val;
    txModeDac = dac;
    txEnable = 1'h1;
    wait_start(2000);
    if (prevStart != 0) check(16'(cyc - prevStart), 16'(19 * 11 * CHIP));
    prevStart = cyc;
    txBitValue = ~val;
    txModeDac = ~dac;
    repeat (5) @(negedge clk_sys);
    for (int k = 0; k < 33; k++) begin
      check({toneActive, chipMark}, {1'h1, word[10 - k % 11]});
      repeat (CHIP) @(negedge clk_sys);
    end
    check({toneActive, pwmSeen_q, dacSeen_q}, {1'h0, ~dac, dac});
  endtask : sc_packet
  // dropping enable right after a start lets the cycle finish, then stays idle
  task automatic sc_stop();
    int n;
    n = 0;
    wait_start(2000);
    txEnable = 1'h0;
    repeat (3400) begin
      @(negedge clk_sys);
      n += int'(cycleStart === 1'h1);
    end
    check(16'(n), 16'h0);
    check({toneActive, pwmOut, dacSample}, {2'h0, 8'h80});
    txEnable = 1'h1;
    wait_start(8);
  endtask : sc_stop
  task automatic sc_reset();
    repeat (40) @(negedge clk_sys);
    rst_b = 1'h0;
    @(negedge clk_sys);
    check({toneActive, chipMark, cycleStart, pwmOut, dacSample}, {4'h0, 8'h80});
    rst_b = 1'h1;
    wait_start(10);
    repeat (5) @(negedge clk_sys);
    check({toneActive, chipMark}, 2'h2);
  endtask : sc_reset
  initial begin
    repeat (5) @(negedge clk_sys);
    rst_b = 1'h1;
    sc_packet(1'h1, 1'h0);
    sc_packet(1'h0, 1'h1);
    sc_stop();
    sc_reset();
    give_verdict();
  end
endmodule : fkt_keepalive_tx_test
